// >>> standby_halt_pkg.sv
// Constants for the standby and halt controller.
// Assumes one 200 MHz core clock that also stands for the oscillator input.
package standby_halt_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  CTRL_OFS      = 4'h0;
    localparam logic [3:0]  STATUS_OFS    = 4'h1;
    // Control register fields
    localparam int          MODE_LSB      = 0;
    localparam int          DRV_BIT       = 2;
    localparam int          WDEN_BIT      = 3;
    localparam logic [7:0]  CTRL_RST      = 8'h08;
    // Status register fields
    localparam int          STATE_LSB     = 0;
    localparam int          HELD_LSB      = 3;
    localparam int          BUSREL_BIT    = 5;
    // Halt mode encodings
    localparam logic [1:0]  MODE_RUN      = 2'h0;
    localparam logic [1:0]  MODE_STOP     = 2'h1;
    localparam logic [1:0]  MODE_IDLE1    = 2'h2;
    localparam logic [1:0]  MODE_IDLE2    = 2'h3;
    // Interrupt source codes, higher code wins
    localparam logic [1:0]  SRC_NONE      = 2'h0;
    localparam logic [1:0]  SRC_OTHER     = 2'h1;
    localparam logic [1:0]  SRC_EXT0      = 2'h2;
    localparam logic [1:0]  SRC_NMI       = 2'h3;
    // Timing
    localparam int          CLK_MHZ       = 200;
    localparam int          OSC_PER_STATE = 2;
    localparam int          ENTRY_OSC     = 3;
    localparam int          ENTRY_CYCLES  = ENTRY_OSC;
    localparam int          WARMUP_STATES = 16;
    localparam int          CNT_W         = 16;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_ENTER = 3'b001,
        ST_HALT  = 3'b010,
        ST_WARM  = 3'b011,
        ST_SERVE = 3'b100
    } halt_state_e;
endpackage

// >>> standby_halt_control.sv
// Halt entry, stop gating, warm-up and release-interrupt ordering.
// Assumes CPU pulses halt_exec once per halt instruction, in core_clk.
// Overview of operation
// [RQ1] Internal stop rises when the mode selects stop and the halt instruction runs.
// [RQ2] With the drive-in-stop bit set, internal stop stays low even in stop halt.
// [RQ3] Halt in stop mode drops the oscillator enable low.
// [RQ4] Release from stop runs a warm-up count that holds the system clock off.
// [RQ5] One state is two oscillator clocks and all state timing uses it.
// [RQ6] NMI or external interrupt zero during the three-clock halt entry is held pending.
// [RQ7] After full entry a new interrupt releases halt; higher of it and held goes first.
// [RQ8] The watchdog is enabled from reset until software clears it.
// [RQ9] Watchdog and other I/O keep running while the bus is released.
// [RQ10] When warm-up expires the clock resumes and the releasing interrupt is served.
//
// The address-and-strobe port and the address map were left to the implementer.
module standby_halt_control #(
    parameter int WARMUP_STATES = standby_halt_pkg::WARMUP_STATES
) (
    input  wire logic                                core_clk,
    input  wire logic                                srst,
    input  wire logic [standby_halt_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [standby_halt_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [standby_halt_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                                halt_exec,
    input  wire logic                                nmi_pin_n,
    input  wire logic                                ext_irq_zero,
    input  wire logic                                other_irq,
    input  wire logic                                bus_release,
    output logic                                     internal_stop,
    output logic                                     osc_enable,
    output logic                                     sys_clk_en,
    output logic                                     state_tick,
    output logic                                     watchdog_enable,
    output logic                                     serve_valid,
    output logic      [1:0]                          serve_src
);
    typedef struct packed {
        standby_halt_pkg::halt_state_e st;
        logic [standby_halt_pkg::CNT_W-1:0] cnt;
        logic       phase;
        logic [1:0] mode;
        logic       drv;
        logic       wd_en;
        logic [1:0] nmi_sync;
        logic [1:0] ext_sync;
        logic [2:0] irq_seen;
        logic [1:0] held;
        logic [1:0] first;
        logic [1:0] second;
        logic       stop_out;
        logic       osc_out;
        logic       clk_out;
        logic       srv_v;
        logic [1:0] srv_src;
        logic [7:0] rdata;
    } ctl_s;

    ctl_s q;
    ctl_s d;
    logic       nmi_lvl;
    logic       ext_lvl;
    logic       new_req;
    logic [1:0] new_src;
    logic [2:0] req_lvl;
    logic [2:0] req_rise;

    // Pins pass two flops; only the second stage is looked at
    assign nmi_lvl = ~q.nmi_sync[1];
    assign ext_lvl = q.ext_sync[1];
    // Edges per source, so a held pin left asserted cannot mask a newer source
    assign req_lvl  = {nmi_lvl, ext_lvl, other_irq};
    assign req_rise = req_lvl & ~q.irq_seen;
    assign new_req  = |req_rise;
    assign new_src  = req_rise[2] ? standby_halt_pkg::SRC_NMI
                    : req_rise[1] ? standby_halt_pkg::SRC_EXT0
                    : req_rise[0] ? standby_halt_pkg::SRC_OTHER
                    : standby_halt_pkg::SRC_NONE;

    always_comb
    begin
        d          = q;
        d.nmi_sync = {q.nmi_sync[0], nmi_pin_n};
        d.ext_sync = {q.ext_sync[0], ext_irq_zero};
        d.phase    = ~q.phase; // RQ5
        d.srv_v    = 1'b0;
        d.srv_src  = standby_halt_pkg::SRC_NONE;
        d.rdata    = 8'h00;
        // Watchdog and I/O registers ignore bus_release on purpose
        if (reg_wr && reg_addr == standby_halt_pkg::CTRL_OFS) // RQ9
        begin
            d.mode  = reg_wdata[standby_halt_pkg::MODE_LSB +: 2];
            d.drv   = reg_wdata[standby_halt_pkg::DRV_BIT];
            d.wd_en = reg_wdata[standby_halt_pkg::WDEN_BIT]; // RQ8
        end
        if (reg_rd)
        begin
            case (reg_addr)
                standby_halt_pkg::CTRL_OFS:
                    d.rdata = {4'h0, q.wd_en, q.drv, q.mode};
                standby_halt_pkg::STATUS_OFS:
                    d.rdata = {2'h0, bus_release, q.held, q.st};
                default:
                    d.rdata = 8'h00;
            endcase
        end
        case (q.st)
            standby_halt_pkg::ST_RUN:
            begin
                if (halt_exec)
                begin
                    d.st      = standby_halt_pkg::ST_ENTER;
                    d.cnt     = standby_halt_pkg::CNT_W'(standby_halt_pkg::ENTRY_CYCLES - 1);
                    d.clk_out = 1'b0;
                    d.held    = standby_halt_pkg::SRC_NONE;
                    d.irq_seen = 3'h0;
                end
            end
            standby_halt_pkg::ST_ENTER:
            begin
                // NMI or external interrupt zero here is latched but does not release
                if ((nmi_lvl || ext_lvl) && q.held == standby_halt_pkg::SRC_NONE)
                    d.held = nmi_lvl ? standby_halt_pkg::SRC_NMI
                                     : standby_halt_pkg::SRC_EXT0; // RQ6
                d.irq_seen = req_lvl;
                if (q.cnt == '0)
                begin
                    d.st = standby_halt_pkg::ST_HALT;
                    if (q.mode == standby_halt_pkg::MODE_STOP)
                    begin
                        d.osc_out  = 1'b0;   // RQ3
                        d.stop_out = ~q.drv; // RQ1 RQ2
                    end
                end
                else
                    d.cnt = q.cnt - 1'b1;
            end
            standby_halt_pkg::ST_HALT:
            begin
                // A level still high from entry is not a new request
                d.irq_seen = req_lvl;
                if (new_req) // RQ7
                begin
                    d.stop_out = 1'b0;
                    d.osc_out  = 1'b1;
                    if (new_src >= q.held)
                    begin
                        d.first  = new_src;
                        d.second = q.held;
                    end
                    else
                    begin
                        d.first  = q.held;
                        d.second = new_src;
                    end
                    if (q.mode == standby_halt_pkg::MODE_STOP)
                    begin
                        d.st  = standby_halt_pkg::ST_WARM; // RQ4
                        d.cnt = standby_halt_pkg::CNT_W'(WARMUP_STATES - 1);
                    end
                    else
                    begin
                        d.st      = standby_halt_pkg::ST_SERVE;
                        d.clk_out = 1'b1;
                    end
                end
            end
            standby_halt_pkg::ST_WARM:
            begin
                // Counts states, so it advances on every second clock
                if (q.phase) // RQ5
                begin
                    if (q.cnt == '0)
                    begin
                        d.st      = standby_halt_pkg::ST_SERVE;
                        d.clk_out = 1'b1; // RQ10
                    end
                    else
                        d.cnt = q.cnt - 1'b1;
                end
            end
            standby_halt_pkg::ST_SERVE:
            begin
                d.srv_v   = 1'b1; // RQ7 RQ10
                d.srv_src = q.first;
                d.held    = standby_halt_pkg::SRC_NONE;
                if (q.second != standby_halt_pkg::SRC_NONE)
                begin
                    d.first  = q.second;
                    d.second = standby_halt_pkg::SRC_NONE;
                end
                else
                    d.st = standby_halt_pkg::ST_RUN;
            end
            default:
                d.st = standby_halt_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q          <= '0;
            q.st       <= standby_halt_pkg::ST_RUN;
            q.mode     <= standby_halt_pkg::CTRL_RST[standby_halt_pkg::MODE_LSB +: 2];
            q.drv      <= standby_halt_pkg::CTRL_RST[standby_halt_pkg::DRV_BIT];
            q.wd_en    <= standby_halt_pkg::CTRL_RST[standby_halt_pkg::WDEN_BIT]; // RQ8
            q.nmi_sync <= 2'h3;
            q.osc_out  <= 1'b1;
            q.clk_out  <= 1'b1;
        end
        else
            q <= d;
    end

    assign reg_rdata       = q.rdata;
    assign internal_stop   = q.stop_out;
    assign osc_enable      = q.osc_out;
    assign sys_clk_en      = q.clk_out;
    assign state_tick      = q.phase;
    assign watchdog_enable = q.wd_en;
    assign serve_valid     = q.srv_v;
    assign serve_src       = q.srv_src;

    a_stop_rises: assert property (@(posedge core_clk) disable iff (srst) // RQ1
        q.st == standby_halt_pkg::ST_ENTER && q.cnt == '0
        && q.mode == standby_halt_pkg::MODE_STOP && !q.drv |=> internal_stop)
        else $error("stop did not rise after stop halt entry");
    a_stop_drive: assert property (@(posedge core_clk) disable iff (srst) // RQ2
        q.drv && $stable(q.drv) |-> !internal_stop)
        else $error("stop high with drive bit set");
    a_osc_off: assert property (@(posedge core_clk) disable iff (srst) // RQ3
        q.st == standby_halt_pkg::ST_HALT && q.mode == standby_halt_pkg::MODE_STOP
        |-> !osc_enable)
        else $error("oscillator running in stop halt");
    a_warm_clk: assert property (@(posedge core_clk) disable iff (srst) // RQ4
        q.st == standby_halt_pkg::ST_WARM |-> !sys_clk_en && osc_enable)
        else $error("clock out during warm-up");
    a_state_tick: assert property (@(posedge core_clk) disable iff (srst) // RQ5
        state_tick |=> !state_tick ##1 state_tick)
        else $error("state tick not divide by two");
    a_entry_len: assert property (@(posedge core_clk) disable iff (srst) // RQ6
        q.st == standby_halt_pkg::ST_RUN && halt_exec
        |=> q.st == standby_halt_pkg::ST_ENTER [*3] ##1 q.st == standby_halt_pkg::ST_HALT)
        else $error("halt entry not three clocks");
    a_entry_hold: assert property (@(posedge core_clk) disable iff (srst) // RQ6
        q.st == standby_halt_pkg::ST_ENTER && nmi_lvl |=> q.held != standby_halt_pkg::SRC_NONE)
        else $error("request during entry not held");
    a_order: assert property (@(posedge core_clk) disable iff (srst) // RQ7
        serve_valid && $past(serve_valid) |-> serve_src < $past(serve_src))
        else $error("lower priority served first");
    a_wd_reset: assert property (@(posedge core_clk) // RQ8
        $past(srst) |-> watchdog_enable)
        else $error("watchdog off after reset");
    a_serve_clk: assert property (@(posedge core_clk) disable iff (srst) // RQ10
        serve_valid |-> sys_clk_en)
        else $error("serving with clock stopped");

    c_stop_cycle: cover property (@(posedge core_clk) disable iff (srst)
        q.st == standby_halt_pkg::ST_WARM ##[1:1000] serve_valid);
    c_two_serves: cover property (@(posedge core_clk) disable iff (srst)
        serve_valid ##1 serve_valid);
    c_idle_release: cover property (@(posedge core_clk) disable iff (srst)
        q.st == standby_halt_pkg::ST_HALT && q.mode != standby_halt_pkg::MODE_STOP
        ##1 q.st == standby_halt_pkg::ST_SERVE);
endmodule // standby_halt_control

// >>> irq_cpu_model.sv
// Behavioural CPU core and interrupt pins facing the standby controller.
// Assumes one core_clk domain; every change lands just after a rising edge.
module irq_cpu_model (
    input  wire logic core_clk,
    output logic      halt_exec,
    output logic      nmi_pin_n,
    output logic      ext_irq_zero,
    output logic      other_irq
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        halt_exec    = 1'h0;
        nmi_pin_n    = 1'h1;
        ext_irq_zero = 1'h0;
        other_irq    = 1'h0;
    end

    // Optional pin request lands inside the halt entry window
    task automatic halt(input logic [1:0] held);
        @(posedge core_clk);
        halt_exec <= 1'h1;
        if (held == standby_halt_pkg::SRC_NMI)
            nmi_pin_n <= 1'h0;
        if (held == standby_halt_pkg::SRC_EXT0)
            ext_irq_zero <= 1'h1;
        @(posedge core_clk);
        halt_exec <= 1'h0;
    endtask

    task automatic raise_other();
        @(posedge core_clk);
        other_irq <= 1'h1;
    endtask

    // Levels must drop before the next halt or they never rise again
    task automatic quiet();
        @(posedge core_clk);
        nmi_pin_n    <= 1'h1;
        ext_irq_zero <= 1'h0;
        other_irq    <= 1'h0;
    endtask
endmodule // irq_cpu_model

// >>> tb_standby_halt_control.sv
// Self-checking bench for the standby and halt controller.
// Assumes irq_cpu_model drives the CPU and interrupt side; warm-up shortened to 2.
module tb_standby_halt_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic       core_clk = 1'h0;
    logic       srst, reg_wr, reg_rd, bus_release;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       halt_exec, nmi_pin_n, ext_irq_zero, other_irq;
    logic       internal_stop, osc_enable, sys_clk_en, state_tick;
    logic       watchdog_enable, serve_valid;
    logic [1:0] serve_src;
    int         fail_count, total_checks, cycles, n;
    logic       t;
    logic [7:0] rows [4][4] = '{'{4'h0, 8'h01, 8'h01, 8'h00}, '{4'h7, 8'hFF, 8'h00, 8'h00},
                                '{4'h1, 8'hFF, 8'h00, 8'h00}, '{4'h0, 8'h0D, 8'h0D, 8'h01}};
    logic [1:0] held [2] = '{standby_halt_pkg::SRC_NMI, standby_halt_pkg::SRC_EXT0};

    always #2.5 core_clk = ~core_clk;

    standby_halt_control #(.WARMUP_STATES(2)) dut (.core_clk(core_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .halt_exec(halt_exec), .nmi_pin_n(nmi_pin_n),
        .ext_irq_zero(ext_irq_zero), .other_irq(other_irq), .bus_release(bus_release),
        .internal_stop(internal_stop), .osc_enable(osc_enable), .sys_clk_en(sys_clk_en),
        .state_tick(state_tick), .watchdog_enable(watchdog_enable),
        .serve_valid(serve_valid), .serve_src(serve_src));
    irq_cpu_model m (.core_clk(core_clk), .halt_exec(halt_exec), .nmi_pin_n(nmi_pin_n),
        .ext_irq_zero(ext_irq_zero), .other_irq(other_irq));

    task automatic close_out();
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk8(reg_rdata, exp);
    endtask

    // Bounded wait, then checks the first serve pulse's source
    task automatic wait_serve(input logic [1:0] exp);
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1 n++;
        end while (serve_valid !== 1'h1 && n < 100);
        chk8({6'h00, serve_src}, {6'h00, exp});
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out();
        end
    end

    initial
    begin
        {srst, reg_wr, reg_rd, bus_release, reg_addr, reg_wdata} = {4'h8, 4'h0, 8'h00};
        repeat (3) @(posedge core_clk);
        srst <= 1'h0;
        #1 chk1(internal_stop, 1'h0);
        chk1(osc_enable, 1'h1);
        chk1(sys_clk_en, 1'h1);
        chk1(watchdog_enable, 1'h1);
        rd(standby_halt_pkg::CTRL_OFS, standby_halt_pkg::CTRL_RST);
        foreach (rows[i])
        begin
            wr(rows[i][0][3:0], rows[i][1]);
            rd(rows[i][0][3:0], rows[i][2]);
            chk1(watchdog_enable, rows[i][3][0]);
        end
        @(posedge core_clk);
        bus_release <= 1'h1;
        rd(standby_halt_pkg::STATUS_OFS, 8'h20);
        chk1(watchdog_enable, 1'h1);
        #1 t = state_tick;
        @(posedge core_clk);
        #1 chk1(state_tick, ~t);
        // Stop halt then warm-up release
        wr(standby_halt_pkg::CTRL_OFS, 8'h01);
        m.halt(standby_halt_pkg::SRC_NONE);
        repeat (3) @(posedge core_clk);
        #1 chk1(internal_stop, 1'h1);
        chk1(osc_enable, 1'h0);
        chk1(sys_clk_en, 1'h0);
        rd(standby_halt_pkg::STATUS_OFS, 8'h22);
        m.raise_other();
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1 n++;
        end while (sys_clk_en !== 1'h1 && n < 100);
        chk1(n >= 4, 1'h1);
        chk1(internal_stop, 1'h0);
        wait_serve(standby_halt_pkg::SRC_OTHER);
        chk1(n == 1, 1'h1);
        m.quiet();
        // Drive-in-stop keeps internal stop low
        wr(standby_halt_pkg::CTRL_OFS, 8'h05);
        m.halt(standby_halt_pkg::SRC_NONE);
        repeat (3) @(posedge core_clk);
        #1 chk1(internal_stop, 1'h0);
        m.raise_other();
        wait_serve(standby_halt_pkg::SRC_OTHER);
        m.quiet();
        // Pin request during idle entry is held, then ordered behind priority
        foreach (held[i])
        begin
            wr(standby_halt_pkg::CTRL_OFS, 8'h02);
            m.halt(held[i]);
            repeat (10) @(posedge core_clk);
            #1 chk1(sys_clk_en, 1'h0);
            chk1(serve_valid, 1'h0);
            m.raise_other();
            wait_serve(held[i]);
            @(posedge core_clk);
            #1 chk1(serve_valid, 1'h1);
            chk8({6'h00, serve_src}, {6'h00, standby_halt_pkg::SRC_OTHER});
            m.quiet();
            repeat (4) @(posedge core_clk);
        end
        close_out();
    end
endmodule // tb_standby_halt_control
